//--- logic/trgen_delay.sv
// Programmable delay line for one bit, counted in clock cycles.
// Assumes the delay changes only while the line is quiet; one edge in flight at a time.
`timescale 1ns/1ps
module trgen_delay import trgen_pkg::*; (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Setting
    input wire logic [31:0] dly_cyc_i,
    // Signal
    input wire logic d_i,
    output logic q_o
);
    // Holds the pending level and counts down to it; a narrow pulse shorter than the
    // delay is carried as one level change at a time, trading fidelity for area.
    logic pend_r;
    logic [31:0] cnt_r;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
            q_o <= 1'b0;
        end else if (cnt_r != 32'h0000_0000) begin
            cnt_r <= cnt_r - 32'h0000_0001;
            if (cnt_r == 32'h0000_0001) begin
                q_o <= pend_r;
            end
        end else if (d_i != q_o) begin
            pend_r <= d_i;
            if (dly_cyc_i == 32'h0000_0000) begin
                q_o <= d_i;
            end else begin
                cnt_r <= dly_cyc_i;
            end
        end
    end
endmodule

//--- logic/trgen_params.svh
// Constants for the trigger generator and port direction block: offsets, fields, resets.
// Assumes it is included by the package and design modules by bare name.
`ifndef TRGEN_PARAMS_SVH
`define TRGEN_PARAMS_SVH

`define TRGEN_OFF_PORT_CTRL 12'h000
`define TRGEN_OFF_PORT_OUT 12'h004
`define TRGEN_OFF_PORT_IN 12'h008
`define TRGEN_OFF_TRIG_CTRL 12'h00C
`define TRGEN_OFF_DELAY 12'h010
`define TRGEN_OFF_GEN_CTRL 12'h014
`define TRGEN_OFF_REPS 12'h018
`define TRGEN_OFF_HOLDOFF 12'h01C
`define TRGEN_OFF_PROGRESS 12'h020
`define TRGEN_OFF_STATUS 12'h024
`define TRGEN_OFF_NVM 12'h028

// Port control: bits 3:0 byte drive, bit 4 clock select, bit 5 interface standard
`define TRGEN_PC_CLKSEL 4
`define TRGEN_PC_IFSTD 5
// Gen control: bit 0 run, bit 1 sync enable
`define TRGEN_GC_RUN 0
`define TRGEN_GC_SYNC 1
// Trigger control: bits 2:0 marker source
`define TRGEN_TC_SRC_W 3
// Progress is a 16-bit fraction of full scale
`define TRGEN_PROG_W 16
`define TRGEN_DLY_W 16
`define TRGEN_RESET_WORD 32'h0000_0000
`define TRGEN_PULSE_CYC 16'h0001
// Clock period in ps; programmed times are in ns
`define TRGEN_CLK_PS 5000
`define TRGEN_NS_TO_PS 1000

`endif

//--- logic/trgen_pkg.sv
// Types for the trigger generator block.
// Assumes trgen_params.svh is on the include path.
`include "trgen_params.svh"
package trgen_pkg;
    typedef enum logic [1:0] {
        TRGEN_IDLE = 2'b00,
        TRGEN_WAIT_SYNC = 2'b01,
        TRGEN_PULSE = 2'b10,
        TRGEN_HOLD = 2'b11
    } trgen_state_e;

    typedef enum logic [2:0] {
        TRGEN_MK_GEN = 3'b000,
        TRGEN_MK_TRIG_IN = 3'b001,
        TRGEN_MK_RUNNING = 3'b010,
        TRGEN_MK_LOW = 3'b011,
        TRGEN_MK_HIGH = 3'b100
    } trgen_mk_src_e;

    // Convert a time in ns to clock cycles, rounded to nearest, at least one
    function automatic logic [31:0] trgen_ns_to_cyc(input logic [31:0] ns);
        logic [47:0] ps;
        logic [47:0] c;
        ps = 48'(ns) * 48'(`TRGEN_NS_TO_PS);
        c = (ps + 48'(`TRGEN_CLK_PS / 2)) / 48'(`TRGEN_CLK_PS);
        trgen_ns_to_cyc = (c == 48'h0000_0000_0000) ? 32'h0000_0001 : c[31:0];
    endfunction
endpackage

//--- logic/trgen_sync3.sv
// Three-flop pin synchroniser; the output changes once stages two and three agree.
// Assumes an asynchronous input and the block clock.
`timescale 1ns/1ps
module trgen_sync3 import trgen_pkg::*; #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    q_o[g] <= 1'b0;
                end else if (s2_r[g] == s3_r[g]) begin
                    q_o[g] <= s3_r[g];
                end
            end
        end
    endgenerate
endmodule

//--- logic/trgen_top.sv
// Trigger generator, marker routing and parallel port direction control with AHB-Lite slave.
// Assumes a single-master AHB-Lite bus at mclk_i; pins arrive asynchronously.
// Functional notes
// - Parallel port is four 8-bit groups, each independently input or output.
// - Group with drive set outputs configured values on its eight pins.
// - Group with drive clear is released; its pins are sampled and reported.
// - Software selects internal or external clock for the parallel port.
// - Interface standard selection kept in non-volatile storage across reboots.
// - Low trigger flag reads set while trigger input is low.
// - High trigger flag reads set while trigger input is high.
// - Selected source signal is routed to the marker output pin.
// - Marker delay is extra delay plus general output delay.
// - Run control starts the generator; clearing it halts it.
// - Generator emits exactly the configured repetitions, then stops.
// - Consecutive generated pulses are spaced by the holdoff interval.
// - Progress reports emitted fraction of configured repetitions.
// - With sync enabled, generation waits until all participants are ready.
// - With sync enabled, readiness check and generation repeat until disabled.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "trgen_params.svh"
module trgen_top import trgen_pkg::*; (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Parallel port pins
    input wire logic [31:0] parallel_port_i,
    output logic [31:0] parallel_port_o,
    output logic [3:0] byte_group_output_enable_n_o,
    output logic port_clk_ext_sel_o,
    output logic port_if_std_o,
    // Non-volatile storage of interface standard
    input wire logic nvm_if_std_i,
    output logic nvm_wr_o,
    output logic nvm_wdata_o,
    // Trigger and marker pins, sync participants
    input wire logic trig_in_i,
    output logic marker_o,
    input wire logic [3:0] sync_ready_i,
    output logic sync_armed_o
);
    logic [31:0] port_ctrl_r;
    logic [31:0] port_out_r;
    logic [31:0] trig_ctrl_r;
    logic [31:0] delay_r;
    logic [31:0] gen_ctrl_r;
    logic [31:0] reps_r;
    logic [31:0] holdoff_r;
    logic [31:0] pin_s;
    logic trig_s;
    logic [3:0] sync_s;
    logic ph_valid_r;
    logic ph_write_r;
    logic [11:0] ph_addr_r;
    logic nvm_loaded_r;
    trgen_state_e state_r;
    logic [31:0] emitted_r;
    logic [31:0] hold_cnt_r;
    logic [31:0] hold_cyc;
    logic [31:0] mk_dly_cyc;
    logic gen_pulse_r;
    logic run_d_r;
    logic mk_src_sig;
    logic [`TRGEN_PROG_W-1:0] progress_r;
    logic run;
    logic sync_en;
    logic all_ready;

    assign run = gen_ctrl_r[`TRGEN_GC_RUN];
    assign sync_en = gen_ctrl_r[`TRGEN_GC_SYNC];
    assign all_ready = &sync_s;

    // Pins are asynchronous to mclk_i
    trgen_sync3 #(.W(37)) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i({sync_ready_i, trig_in_i, parallel_port_i}),
        .q_o({sync_s, trig_s, pin_s})
    );

    // AHB-Lite address phase capture; slave is ready from the first cycle after reset (not ready during reset), answer always OKAY
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_valid_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_addr_r <= 12'h000;
        end else if (hready_i) begin
            ph_valid_r <= hsel_i && htrans_i[1];
            ph_write_r <= hwrite_i;
            ph_addr_r <= haddr_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hreadyout_o <= 1'b0;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    function automatic logic wr_hit(input logic [11:0] off);
        wr_hit = ph_valid_r && ph_write_r && (ph_addr_r == off);
    endfunction

    // Register writes; reads of unmapped offsets return zero
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            port_ctrl_r <= `TRGEN_RESET_WORD;
            port_out_r <= `TRGEN_RESET_WORD;
            trig_ctrl_r <= `TRGEN_RESET_WORD;
            delay_r <= `TRGEN_RESET_WORD;
            gen_ctrl_r <= `TRGEN_RESET_WORD;
            reps_r <= `TRGEN_RESET_WORD;
            holdoff_r <= `TRGEN_RESET_WORD;
            nvm_loaded_r <= 1'b0;
        end else begin
            if (!nvm_loaded_r) begin
                nvm_loaded_r <= 1'b1;
                port_ctrl_r[`TRGEN_PC_IFSTD] <= nvm_if_std_i;
            end
            if (wr_hit(`TRGEN_OFF_PORT_CTRL)) begin
                port_ctrl_r <= {26'h000_0000, hwdata_i[5:0]};
            end
            if (wr_hit(`TRGEN_OFF_PORT_OUT)) begin
                port_out_r <= hwdata_i;
            end
            if (wr_hit(`TRGEN_OFF_TRIG_CTRL)) begin
                trig_ctrl_r <= {29'h0000_0000, hwdata_i[2:0]};
            end
            if (wr_hit(`TRGEN_OFF_DELAY)) begin
                delay_r <= hwdata_i;
            end
            if (wr_hit(`TRGEN_OFF_GEN_CTRL)) begin
                gen_ctrl_r <= {30'h0000_0000, hwdata_i[1:0]};
            end else if (state_r == TRGEN_PULSE && !sync_en && run &&
                         emitted_r + 32'h0000_0001 >= reps_r) begin
                gen_ctrl_r[`TRGEN_GC_RUN] <= 1'b0;
            end
            if (wr_hit(`TRGEN_OFF_REPS)) begin
                reps_r <= hwdata_i;
            end
            if (wr_hit(`TRGEN_OFF_HOLDOFF)) begin
                holdoff_r <= hwdata_i;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            nvm_wr_o <= 1'b0;
            nvm_wdata_o <= 1'b0;
        end else begin
            nvm_wr_o <= wr_hit(`TRGEN_OFF_PORT_CTRL);
            nvm_wdata_o <= hwdata_i[`TRGEN_PC_IFSTD];
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else begin
            case (haddr_i)
                `TRGEN_OFF_PORT_CTRL: hrdata_o <= port_ctrl_r;
                `TRGEN_OFF_PORT_OUT: hrdata_o <= port_out_r;
                `TRGEN_OFF_PORT_IN: hrdata_o <= pin_s;
                `TRGEN_OFF_TRIG_CTRL: hrdata_o <= trig_ctrl_r;
                `TRGEN_OFF_DELAY: hrdata_o <= delay_r;
                `TRGEN_OFF_GEN_CTRL: hrdata_o <= gen_ctrl_r;
                `TRGEN_OFF_REPS: hrdata_o <= reps_r;
                `TRGEN_OFF_HOLDOFF: hrdata_o <= holdoff_r;
                `TRGEN_OFF_PROGRESS: hrdata_o <= {16'h0000, progress_r};
                `TRGEN_OFF_STATUS: hrdata_o <= {24'h00_0000, emitted_r[3:0],
                                                all_ready, state_r != TRGEN_IDLE,
                                                trig_s, !trig_s};
                default: hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_byte
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    byte_group_output_enable_n_o[g] <= 1'b1;
                    parallel_port_o[g*8 +: 8] <= 8'h00;
                end else begin
                    byte_group_output_enable_n_o[g] <= !port_ctrl_r[g];
                    parallel_port_o[g*8 +: 8] <= port_out_r[g*8 +: 8];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            port_clk_ext_sel_o <= 1'b0;
            port_if_std_o <= 1'b0;
            sync_armed_o <= 1'b0;
        end else begin
            port_clk_ext_sel_o <= port_ctrl_r[`TRGEN_PC_CLKSEL];
            port_if_std_o <= port_ctrl_r[`TRGEN_PC_IFSTD];
            sync_armed_o <= state_r == TRGEN_WAIT_SYNC;
        end
    end

    // times in ns rounded to cycles
    assign hold_cyc = trgen_ns_to_cyc(holdoff_r);
    // extra delay plus general output delay
    assign mk_dly_cyc = trgen_ns_to_cyc({16'h0000, delay_r[31:16]}
                                        + {16'h0000, delay_r[15:0]});

    // Generator
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= TRGEN_IDLE;
            emitted_r <= 32'h0000_0000;
            hold_cnt_r <= 32'h0000_0000;
            gen_pulse_r <= 1'b0;
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= run;
            gen_pulse_r <= 1'b0;
            case (state_r)
                TRGEN_IDLE: begin
                    if (run && !run_d_r) begin
                        emitted_r <= 32'h0000_0000;
                        if (reps_r != 32'h0000_0000) begin
                            state_r <= sync_en ? TRGEN_WAIT_SYNC : TRGEN_PULSE;
                        end
                    end
                end
                TRGEN_WAIT_SYNC: begin
                    if (!run || !sync_en) begin
                        state_r <= TRGEN_IDLE;
                    end else if (all_ready) begin
                        emitted_r <= 32'h0000_0000;
                        state_r <= TRGEN_PULSE;
                    end
                end
                TRGEN_PULSE: begin
                    if (!run) begin
                        state_r <= TRGEN_IDLE;
                    end else begin
                        gen_pulse_r <= 1'b1;
                        emitted_r <= emitted_r + 32'h0000_0001;
                        hold_cnt_r <= hold_cyc;
                        state_r <= TRGEN_HOLD;
                    end
                end
                TRGEN_HOLD: begin
                    if (!run) begin
                        state_r <= TRGEN_IDLE;
                    end else if (hold_cnt_r > 32'h0000_0001) begin
                        hold_cnt_r <= hold_cnt_r - 32'h0000_0001;
                    end else if (emitted_r < reps_r) begin
                        state_r <= TRGEN_PULSE;
                    end else if (sync_en) begin
                        state_r <= TRGEN_WAIT_SYNC;
                    end else begin
                        state_r <= TRGEN_IDLE;
                    end
                end
                default: state_r <= TRGEN_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            progress_r <= 16'h0000;
        end else if (reps_r == 32'h0000_0000 || (run && !run_d_r)) begin
            progress_r <= 16'h0000;
        end else begin
            progress_r <= 16'((({emitted_r, 16'h0000} - {16'h0000, emitted_r})
                              / {16'h0000, reps_r}));
        end
    end

    always_comb begin
        case (trgen_mk_src_e'(trig_ctrl_r[`TRGEN_TC_SRC_W-1:0]))
            TRGEN_MK_GEN: mk_src_sig = gen_pulse_r;
            TRGEN_MK_TRIG_IN: mk_src_sig = trig_s;
            TRGEN_MK_RUNNING: mk_src_sig = state_r != TRGEN_IDLE;
            TRGEN_MK_LOW: mk_src_sig = !trig_s;
            TRGEN_MK_HIGH: mk_src_sig = 1'b1;
            default: mk_src_sig = 1'b0;
        endcase
    end

    trgen_delay u_mk_dly (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .dly_cyc_i(mk_dly_cyc),
        .d_i(mk_src_sig),
        .q_o(marker_o)
    );

    // Assertions
    hold_space_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        gen_pulse_r && run |=> !gen_pulse_r)
        else $error("pulse spacing broken");
    no_over_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_r == TRGEN_PULSE && run |-> emitted_r < reps_r)
        else $error("too many pulses");
    start_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_r == TRGEN_IDLE && run && !run_d_r |=> emitted_r == 32'h0000_0000)
        else $error("count not cleared on start");
    sync_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_r == TRGEN_WAIT_SYNC && !all_ready |=> state_r != TRGEN_PULSE)
        else $error("pulse without ready");
    sync_repeat_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        state_r == TRGEN_HOLD && run && sync_en && hold_cnt_r <= 32'h0000_0001
        && emitted_r >= reps_r |=> state_r == TRGEN_WAIT_SYNC)
        else $error("sync cycle not repeated");
    stop_halt_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !run && state_r != TRGEN_IDLE |=> state_r == TRGEN_IDLE)
        else $error("generator not halted");
    drive_en_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        port_ctrl_r[0] |=> !byte_group_output_enable_n_o[0])
        else $error("group not driven");
    lvl_flag_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(trig_s) |-> ##2 hrdata_o[1] || haddr_i != `TRGEN_OFF_STATUS
        || $past(haddr_i) != `TRGEN_OFF_STATUS)
        else $error("high flag wrong");
endmodule

//--- verif/testbench.sv
// Directed bench for the trigger generator block over AHB-Lite.
// Assumes the far-side model and the design files are compiled first.
`timescale 1ns/1ps
`include "trgen_params.svh"
module testbench import trgen_pkg::*; ();
    logic mclk_i, rst_i, hsel, hwrite, hready, hresp, prev_mk, nvm_std, nvm_wr, nvm_wd;
    logic clk_sel, if_std, trig_lvl, trig, marker, armed, nvm_last;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, rd, pin, pout, ext;
    logic [3:0] oe_n, rdy, syn_rdy;
    int fail_count, num_checks, cyc, pulses, gap, last_rise, nvm_cnt;

    trgen_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .parallel_port_i(pin), .parallel_port_o(pout), .byte_group_output_enable_n_o(oe_n),
        .port_clk_ext_sel_o(clk_sel), .port_if_std_o(if_std), .nvm_if_std_i(nvm_std),
        .nvm_wr_o(nvm_wr), .nvm_wdata_o(nvm_wd), .trig_in_i(trig), .marker_o(marker),
        .sync_ready_i(syn_rdy), .sync_armed_o(armed));
    trgen_far_model far (.mclk_i(mclk_i), .port_o_i(pout), .oe_n_i(oe_n), .ext_val_i(ext),
        .trig_lvl_i(trig_lvl), .ready_i(rdy), .port_wire_o(pin), .trig_o(trig),
        .sync_ready_o(syn_rdy));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Pulse spacing, store writes and the hang limit, all seen at the rising edge
    always @(posedge mclk_i) begin
        cyc++;
        if (nvm_wr === 1'b1) begin
            nvm_cnt++;
            nvm_last = nvm_wd;
        end
        if (marker === 1'b1 && prev_mk === 1'b0) begin
            pulses++;
            gap = cyc - last_rise;
            last_rise = cyc;
        end
        prev_mk = marker;
        if (cyc > 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic wait_ready();
        do @(posedge mclk_i); while (hready !== 1'b1);
    endtask
    // Address phase held until hready, then data phase held until hready again
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, exp, rd);
    endtask
    task automatic do_reset();
        @(posedge mclk_i);
        rst_i <= 1'b1;
        cycles(12);
        rst_i <= 1'b0;
        cycles(2);
    endtask
    // Cycles from a trigger pin change to the marker change
    task automatic lat(output int n);
        logic m0;
        @(posedge mclk_i);
        m0 = marker;
        trig_lvl <= ~trig_lvl;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (marker === m0 && n < 100);
        cycles(10);
    endtask
    function automatic logic [31:0] bmask(input logic [3:0] g);
        return {{8{g[3]}}, {8{g[2]}}, {8{g[1]}}, {8{g[0]}}};
    endfunction

    initial begin
        logic [31:0] m, ov;
        logic [3:0] masks [4];
        trgen_mk_src_e srcs [6];
        logic [5:0] lv, ex;
        int base, n, n0, n1;
        masks = '{4'h5, 4'hA, 4'hF, 4'h0};
        srcs = '{TRGEN_MK_HIGH, TRGEN_MK_LOW, TRGEN_MK_LOW, TRGEN_MK_TRIG_IN,
            TRGEN_MK_TRIG_IN, TRGEN_MK_RUNNING};
        lv = 6'b10_1100;
        ex = 6'b00_1011;
        rst_i = 1'b1;
        {hsel, hwrite, nvm_std, trig_lvl, htrans, haddr, hwdata} = '0;
        ext = 32'h1234_5678;
        rdy = 4'h0;
        cycles(12);
        rst_i <= 1'b0;
        cycles(2);
        chk("enables at reset", 32'h0000_000F, 32'(oe_n));
        rdchk("unmapped", 12'h0FC, 32'h0000_0000);
        chk("okay response", 32'h0000_0000, 32'(hresp));
        for (int i = 0; i < 2; i++) begin
            trig_lvl <= i[0];
            cycles(8);
            rdchk("status", `TRGEN_OFF_STATUS, i[0] ? 32'h0000_0002 : 32'h0000_0001);
        end
        $display("test trigger status done");
        for (int i = 0; i < 4; i++) begin
            m = bmask(masks[i]);
            ov = 32'hA5A5_5A5A ^ 32'(i);
            ext <= 32'h1234_5678 + 32'(i);
            wr(`TRGEN_OFF_PORT_OUT, ov);
            wr(`TRGEN_OFF_PORT_CTRL, {28'h000_0000, masks[i]});
            cycles(8);
            chk("drive enables", {28'h000_0000, ~masks[i]}, {28'h000_0000, oe_n});
            chk("port out", ov & m, pout & m);
            rdchk("port in", `TRGEN_OFF_PORT_IN, (ov & m) | (ext & ~m));
        end
        $display("test port direction done");
        base = nvm_cnt;
        wr(`TRGEN_OFF_PORT_CTRL, 32'h0000_0030);
        cycles(3);
        chk("clock ext", 32'h0000_0001, 32'(clk_sel));
        chk("if std", 32'h0000_0001, 32'(if_std));
        chk("store writes", 32'(base + 1), 32'(nvm_cnt));
        chk("store data", 32'h0000_0001, 32'(nvm_last));
        wr(`TRGEN_OFF_PORT_CTRL, 32'h0000_0000);
        cycles(3);
        chk("clock int", 32'h0000_0000, 32'(clk_sel));
        nvm_std <= 1'b1;
        do_reset();
        cycles(2);
        chk("if std restored", 32'h0000_0001, 32'(if_std));
        rdchk("port ctrl restored", `TRGEN_OFF_PORT_CTRL, 32'h0000_0020);
        $display("test clock and standard done");
        wr(`TRGEN_OFF_DELAY, 32'h0000_0000);
        for (int i = 0; i < 6; i++) begin
            trig_lvl <= lv[i];
            wr(`TRGEN_OFF_TRIG_CTRL, 32'(srcs[i]));
            cycles(20);
            chk("marker source", 32'(ex[i]), 32'(marker));
        end
        $display("test marker source done");
        wr(`TRGEN_OFF_TRIG_CTRL, 32'(TRGEN_MK_TRIG_IN));
        wr(`TRGEN_OFF_DELAY, 32'h0000_000A);
        lat(n0);
        wr(`TRGEN_OFF_DELAY, 32'h000D_000A);
        lat(n1);
        chk("delay 23ns", 32'h0000_0003, 32'(n1 - n0));
        wr(`TRGEN_OFF_DELAY, 32'h000C_000A);
        lat(n1);
        chk("delay 22ns", 32'h0000_0002, 32'(n1 - n0));
        wr(`TRGEN_OFF_DELAY, 32'h000A_0000);
        lat(n1);
        chk("extra only", 32'(n0), 32'(n1));
        $display("test marker delay done");
        wr(`TRGEN_OFF_TRIG_CTRL, 32'(TRGEN_MK_GEN));
        wr(`TRGEN_OFF_DELAY, 32'h0000_0000);
        wr(`TRGEN_OFF_REPS, 32'h0000_0003);
        wr(`TRGEN_OFF_HOLDOFF, 32'h0000_0016);
        base = pulses;
        wr(`TRGEN_OFF_GEN_CTRL, 32'h0000_0001);
        cycles(60);
        chk("pulse count", 32'h0000_0003, 32'(pulses - base));
        chk("pulse period", 32'h0000_0005, 32'(gap));
        rdchk("progress full", `TRGEN_OFF_PROGRESS, 32'h0000_FFFF);
        rdchk("run cleared", `TRGEN_OFF_GEN_CTRL, 32'h0000_0000);
        rdchk("status emitted", `TRGEN_OFF_STATUS, 32'h0000_0032);
        wr(`TRGEN_OFF_REPS, 32'h0000_0002);
        wr(`TRGEN_OFF_HOLDOFF, 32'h0000_00C8);
        base = pulses;
        wr(`TRGEN_OFF_GEN_CTRL, 32'h0000_0001);
        n = 0;
        while (pulses == base && n < 100) begin
            cycles(1);
            n++;
        end
        rdchk("progress half", `TRGEN_OFF_PROGRESS, 32'h0000_7FFF);
        cycles(80);
        chk("pulse count", 32'h0000_0002, 32'(pulses - base));
        chk("pulse period", 32'h0000_0029, 32'(gap));
        wr(`TRGEN_OFF_REPS, 32'h0000_0064);
        wr(`TRGEN_OFF_HOLDOFF, 32'h0000_0016);
        wr(`TRGEN_OFF_GEN_CTRL, 32'h0000_0001);
        cycles(30);
        wr(`TRGEN_OFF_GEN_CTRL, 32'h0000_0000);
        cycles(5);
        base = pulses;
        cycles(50);
        chk("halted", 32'(base), 32'(pulses));
        $display("test generator done");
        rdy <= 4'h7;
        wr(`TRGEN_OFF_REPS, 32'h0000_0001);
        base = pulses;
        wr(`TRGEN_OFF_GEN_CTRL, 32'h0000_0003);
        cycles(50);
        chk("held for sync", 32'(base), 32'(pulses));
        chk("armed", 32'h0000_0001, 32'(armed));
        rdy <= 4'hF;
        cycles(100);
        chk("sync repeats", 32'h0000_0001, 32'(pulses - base >= 2));
        wr(`TRGEN_OFF_GEN_CTRL, 32'h0000_0000);
        cycles(5);
        base = pulses;
        cycles(30);
        chk("sync stopped", 32'(base), 32'(pulses));
        $display("test sync done");
        give_verdict();
    end
endmodule

//--- verif/trgen_far_model.sv
// Far-side model: instruments on the parallel port, trigger pin and sync lines.
// Assumes the bench sets their levels; a byte group the design drives wins the wire.
`timescale 1ns/1ps
module trgen_far_model (
    // Clock
    input wire logic mclk_i,
    // Design side of the port
    input wire logic [31:0] port_o_i,
    input wire logic [3:0] oe_n_i,
    // Bench settings
    input wire logic [31:0] ext_val_i,
    input wire logic trig_lvl_i,
    input wire logic [3:0] ready_i,
    // Pins seen by the design
    output logic [31:0] port_wire_o,
    output logic trig_o,
    output logic [3:0] sync_ready_o
);
    // Low enable means the design owns the byte, so our value is masked there
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            port_wire_o[g*8 +: 8] = oe_n_i[g] ? ext_val_i[g*8 +: 8] : port_o_i[g*8 +: 8];
        end
    end
    assign trig_o = trig_lvl_i;
    // ready when prepared
    // Registered so the design never sees readiness in the same cycle it was decided
    always_ff @(posedge mclk_i) begin
        sync_ready_o <= ready_i;
    end
endmodule
